/* File: spipc_cfg.svh */
// timing counts and field positions for the spi pin and select control
`ifndef SPIPC_CFG_SVH
`define SPIPC_CFG_SVH
`define SPIPC_BITS_PER_BYTE 4'h8
`define SPIPC_PRESCALE_WIDTH 7
`define SPIPC_RATE_BITS 3
`define SPIPC_RATE_TIMER1 3'h7
`define SPIPC_CTRL_MASTER_RST 1'b0
`define SPIPC_SCK_IDLE 1'b0
`endif

/* File: spipc_pkg.sv */
// types shared by both ends of the spi pin and select control
package spipc_pkg;
   typedef enum logic [1:0] {
      SPIPC_PM_QUASI = 2'b00,
      SPIPC_PM_PUSHPULL = 2'b01,
      SPIPC_PM_INPUT = 2'b10,
      SPIPC_PM_OPENDRAIN = 2'b11
   } spipc_port_mode_e;
   typedef enum logic [1:0] {
      SPIPC_IDLE = 2'b00,
      SPIPC_HALF_LO = 2'b01,
      SPIPC_HALF_HI = 2'b10
   } spipc_state_e;
   typedef logic [7:0] spipc_byte_t;
endpackage : spipc_pkg

/* File: spipc_bus_if.sv */
// spi bus wires between the device end and the far end
`timescale 1ns/1ps
interface spipc_bus_if;
   logic dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n;
   logic dev_miso_o, dev_miso_oe_n;
   logic far_sck_o, far_sck_oe_n, far_mosi_o, far_mosi_oe_n;
   logic far_miso_o, far_miso_oe_n, far_ss_n;
   logic sck, mosi, miso, ss_n;
   // wire levels resolved from the enables, pulled high when undriven
   assign sck = !dev_sck_oe_n ? dev_sck_o :
                (!far_sck_oe_n ? far_sck_o : 1'b1);
   assign mosi = !dev_mosi_oe_n ? dev_mosi_o :
                 (!far_mosi_oe_n ? far_mosi_o : 1'b1);
   assign miso = !dev_miso_oe_n ? dev_miso_o :
                 (!far_miso_oe_n ? far_miso_o : 1'b1);
   assign ss_n = far_ss_n;
   modport device (
      output dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n,
      output dev_miso_o, dev_miso_oe_n,
      input sck, mosi, miso, ss_n
   );
   modport far (
      output far_sck_o, far_sck_oe_n, far_mosi_o, far_mosi_oe_n,
      output far_miso_o, far_miso_oe_n, far_ss_n,
      input sck, mosi, miso
   );
endinterface : spipc_bus_if

/* File: spipc_device.sv */
// device end: pin direction, select handling, mode fault, byte shifter
//
// Functional notes
// - master drives sck, mosi; slave drives miso
// - remap bit chooses port 1 pin placement
// - programming interface always uses remapped placement
// - eight sck cycles exchange one byte
// - rate bits pick prescaler tap or timer1
// - msb first unless bit order reversed
// - slave drives miso only while selected
// - master selects one slave per message
// - one master and one bit order per bus
// - master with select disable ignores ss
// - low ss demotes master to slave
// - select fault sets flag and interrupt
// - master mode returns only by software
// - select disable change keeps fault flag
// - slave with phase and disable stays selected
// - programmer frames each message with ss
// - enabled port overrides pin directions except in input mode
// - quasi and open drain mosi released idle
// - push pull mosi tristated when idle
// - select ignore keeps master, slave selected
`timescale 1ns/1ps
`include "spipc_cfg.svh"
module spipc_device #(
   parameter int PRESCALE_WIDTH = `SPIPC_PRESCALE_WIDTH
) (
   input wire logic i_clock,
   input wire logic i_rst,
   spipc_bus_if.device bus,
   input wire logic i_port_enable,
   input wire logic i_master_set,
   input wire logic i_select_disable,
   input wire logic i_select_ignore,
   input wire logic i_clock_phase,
   input wire logic i_bit_order_select,
   input wire logic i_remap,
   input wire logic i_isp_active,
   input wire logic [2:0] i_rate_select_bits,
   input wire logic i_timer1_overflow,
   input wire logic i_interrupt_enable,
   input wire logic i_fault_clear,
   input wire spipc_pkg::spipc_port_mode_e i_port_mode,
   input wire logic i_start,
   input wire spipc_pkg::spipc_byte_t i_tx_byte,
   output logic o_master_select,
   output logic o_mode_fault_flag,
   output logic o_irq,
   output logic o_busy,
   output logic o_done,
   output spipc_pkg::spipc_byte_t o_rx_byte,
   output logic o_use_remap,
   output logic [2:0] o_sck_pin,
   output logic [2:0] o_miso_pin,
   output logic [2:0] o_mosi_pin,
   output logic [2:0] o_ss_pin,
   output logic o_ss_gpio_free
);
   import spipc_pkg::*;
   logic master_select;
   logic mode_fault_flag;
   logic ss_meta, ss_sync, sck_prev;
   logic [PRESCALE_WIDTH-1:0] prescale;
   logic [PRESCALE_WIDTH-1:0] prescale_prev;
   logic tick;
   spipc_state_e state;
   logic [3:0] bit_count;
   spipc_byte_t shreg;
   logic sck_out, selected, fault, master_on;
   logic slave_rise, slave_fall;
   // master samples miso on the rising edge and shifts on the falling one
   logic rx_bit;
   spipc_byte_t next_shreg;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ss_meta <= 1'b1;
         ss_sync <= 1'b1;
         // matches the pulled up idle wire, so no false edge after reset
         sck_prev <= 1'b1;
      end else begin
         ss_meta <= bus.ss_n;
         ss_sync <= ss_meta;
         sck_prev <= bus.sck;
      end
   end

   assign master_on = i_port_enable && master_select;
   // fault only when select handling active
   // select disable makes ss a plain pin for a master or with clock phase set
   assign fault = master_on && !ss_sync && !i_select_disable &&
                  !i_select_ignore;
   assign selected = i_select_ignore ||
                     (i_clock_phase && i_select_disable) || !ss_sync;

   // master returns only by software set
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         master_select <= `SPIPC_CTRL_MASTER_RST;
      end else if (fault) begin
         master_select <= 1'b0;
      end else if (i_master_set) begin
         master_select <= 1'b1;
      end
   end

   // fault flag, set wins over clear
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         mode_fault_flag <= 1'b0;
      end else if (fault) begin
         mode_fault_flag <= 1'b1;
      end else if (i_fault_clear) begin
         mode_fault_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         prescale <= '0;
         prescale_prev <= '0;
      end else begin
         prescale <= prescale + 1'b1;
         prescale_prev <= prescale;
      end
   end
   always_comb begin
      if (i_rate_select_bits == `SPIPC_RATE_TIMER1) begin
         tick = i_timer1_overflow;
      end else begin
         tick = prescale[i_rate_select_bits] &&
                !prescale_prev[i_rate_select_bits];
      end
   end

   assign next_shreg = i_bit_order_select ? {rx_bit, shreg[7:1]} :
                       {shreg[6:0], rx_bit};
   assign slave_rise = bus.sck && !sck_prev;
   assign slave_fall = !bus.sck && sck_prev;

   // eight clock byte exchange, master and slave
   // bit order on mosi and miso
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= SPIPC_IDLE;
         bit_count <= 4'h0;
         shreg <= 8'h00;
         sck_out <= `SPIPC_SCK_IDLE;
         rx_bit <= 1'b0;
         o_rx_byte <= 8'h00;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         unique case (state)
            SPIPC_IDLE: begin
               sck_out <= `SPIPC_SCK_IDLE;
               bit_count <= 4'h0;
               if (i_start && i_port_enable) begin
                  shreg <= i_tx_byte;
                  // a slave arms before its select arrives
                  if (master_on) begin
                     state <= SPIPC_HALF_LO;
                  end else begin
                     state <= SPIPC_HALF_HI;
                  end
               end
            end
            SPIPC_HALF_LO: begin
               if (!master_on) begin
                  state <= SPIPC_IDLE;
               end else if (tick) begin
                  sck_out <= 1'b1;
                  rx_bit <= bus.miso;
                  bit_count <= bit_count + 4'h1;
                  state <= SPIPC_HALF_HI;
               end
            end
            SPIPC_HALF_HI: begin
               if (master_on) begin
                  if (tick) begin
                     sck_out <= 1'b0;
                     shreg <= next_shreg;
                     if (bit_count == `SPIPC_BITS_PER_BYTE) begin
                        o_rx_byte <= next_shreg;
                        o_done <= 1'b1;
                        state <= SPIPC_IDLE;
                     end else begin
                        state <= SPIPC_HALF_LO;
                     end
                  end
               end else if (!i_port_enable ||
                            (!selected && bit_count != 4'h0)) begin
                  state <= SPIPC_IDLE;
               end else if (slave_rise) begin
                  shreg <= i_bit_order_select ?
                     {bus.mosi, shreg[7:1]} : {shreg[6:0], bus.mosi};
                  bit_count <= bit_count + 4'h1;
               end else if (slave_fall &&
                            bit_count == `SPIPC_BITS_PER_BYTE) begin
                  o_rx_byte <= shreg;
                  o_done <= 1'b1;
                  state <= SPIPC_IDLE;
               end
            end
            default: state <= SPIPC_IDLE;
         endcase
      end
   end

   always_comb begin
      bus.dev_sck_o = sck_out;
      bus.dev_mosi_o = i_bit_order_select ? shreg[0] : shreg[7];
      bus.dev_miso_o = i_bit_order_select ? shreg[0] : shreg[7];
      bus.dev_sck_oe_n = !(master_on && i_port_mode != SPIPC_PM_INPUT);
      bus.dev_mosi_oe_n = !(master_on && state != SPIPC_IDLE &&
                            i_port_mode != SPIPC_PM_INPUT);
      bus.dev_miso_oe_n = !(i_port_enable && !master_select && selected &&
                            i_port_mode != SPIPC_PM_INPUT);
      if (i_port_mode == SPIPC_PM_OPENDRAIN) begin
         bus.dev_mosi_oe_n = bus.dev_mosi_oe_n || bus.dev_mosi_o;
         bus.dev_miso_oe_n = bus.dev_miso_oe_n || bus.dev_miso_o;
         bus.dev_sck_oe_n = bus.dev_sck_oe_n || sck_out;
      end
   end

   assign o_use_remap = i_remap || i_isp_active;
   assign o_sck_pin = o_use_remap ? 3'h7 : 3'h6;
   assign o_miso_pin = o_use_remap ? 3'h6 : 3'h5;
   assign o_mosi_pin = o_use_remap ? 3'h5 : 3'h7;
   assign o_ss_pin = o_use_remap ? 3'h4 : 3'h1;
   assign o_ss_gpio_free = i_select_ignore ||
      (i_select_disable && (master_select || i_clock_phase));

   assign o_master_select = master_select;
   assign o_mode_fault_flag = mode_fault_flag;
   assign o_irq = mode_fault_flag && i_interrupt_enable;
   assign o_busy = state != SPIPC_IDLE;
endmodule : spipc_device

/* File: spipc_far.sv */
// far end: a plain spi master or slave facing the device
`timescale 1ns/1ps
`include "spipc_cfg.svh"
module spipc_far #(
   parameter int HALF_PERIOD = 4
) (
   input wire logic i_clock,
   input wire logic i_rst,
   spipc_bus_if.far bus,
   input wire logic i_act_master,
   input wire logic i_lsb_first,
   input wire logic i_start,
   input wire spipc_pkg::spipc_byte_t i_tx_byte,
   output spipc_pkg::spipc_byte_t o_rx_byte,
   output logic o_done,
   output logic o_busy
);
   import spipc_pkg::*;
   logic [7:0] div;
   logic [3:0] bit_count;
   spipc_byte_t shreg;
   logic sck_out, sck_prev, rx_bit;
   spipc_byte_t next_shreg;
   spipc_state_e state;
   assign bus.far_mosi_o = i_lsb_first ? shreg[0] : shreg[7];
   assign bus.far_miso_o = i_lsb_first ? shreg[0] : shreg[7];
   assign bus.far_sck_o = sck_out;
   assign bus.far_sck_oe_n = !i_act_master;
   assign bus.far_mosi_oe_n = !(i_act_master && state != SPIPC_IDLE);
   assign bus.far_miso_oe_n = !(!i_act_master && state != SPIPC_IDLE);
   assign next_shreg = i_lsb_first ? {rx_bit, shreg[7:1]} :
                       {shreg[6:0], rx_bit};
   // select held low across each message the far end masters
   assign bus.far_ss_n = !(i_act_master && state != SPIPC_IDLE);
   assign o_busy = state != SPIPC_IDLE;
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= SPIPC_IDLE;
         div <= 8'h00;
         bit_count <= 4'h0;
         shreg <= 8'h00;
         sck_out <= `SPIPC_SCK_IDLE;
         sck_prev <= 1'b1;
         rx_bit <= 1'b0;
         o_rx_byte <= 8'h00;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         sck_prev <= bus.sck;
         div <= (div == 8'(HALF_PERIOD - 1)) ? 8'h00 : div + 8'h01;
         unique case (state)
            SPIPC_IDLE: begin
               bit_count <= 4'h0;
               sck_out <= `SPIPC_SCK_IDLE;
               // a master waits at least one half period after select goes low
               if (i_start) begin
                  shreg <= i_tx_byte;
                  state <= SPIPC_HALF_HI;
               end
            end
            SPIPC_HALF_LO: begin
               if (div == 8'h00) begin
                  sck_out <= 1'b1;
                  rx_bit <= bus.miso;
                  bit_count <= bit_count + 4'h1;
                  state <= SPIPC_HALF_HI;
               end
            end
            SPIPC_HALF_HI: begin
               if (!i_act_master) begin
                  if (bus.sck && !sck_prev) begin
                     shreg <= i_lsb_first ?
                        {bus.mosi, shreg[7:1]} : {shreg[6:0], bus.mosi};
                     bit_count <= bit_count + 4'h1;
                  end else if (!bus.sck && sck_prev &&
                               bit_count == `SPIPC_BITS_PER_BYTE) begin
                     o_rx_byte <= shreg;
                     o_done <= 1'b1;
                     state <= SPIPC_IDLE;
                  end
               end else if (div == 8'h00) begin
                  sck_out <= 1'b0;
                  if (bit_count != 4'h0) begin
                     shreg <= next_shreg;
                  end
                  if (bit_count == `SPIPC_BITS_PER_BYTE) begin
                     o_rx_byte <= next_shreg;
                     o_done <= 1'b1;
                     state <= SPIPC_IDLE;
                  end else begin
                     state <= SPIPC_HALF_LO;
                  end
               end
            end
            default: state <= SPIPC_IDLE;
         endcase
      end
   end
endmodule : spipc_far

/* File: spipc_assertions.sv */
// concurrent checks on the spi wires between the two ends
`timescale 1ns/1ps
module spipc_assertions (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe_n,
   input wire logic dev_mosi_oe_n,
   input wire logic dev_miso_oe_n,
   input wire logic far_miso_oe_n,
   input wire logic ss_n
);
   logic [3:0] sck_rises;
   logic sck_q;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // counts rising sck edges while the device drives mosi
   always_ff @(posedge i_clock) begin
      sck_q <= dev_sck_o;
      if (i_rst || dev_mosi_oe_n) begin
         sck_rises <= 4'h0;
      end else if (dev_sck_o && !sck_q) begin
         sck_rises <= sck_rises + 4'h1;
      end
   end
   a_byte_eight_clocks: assert property (
      $rose(dev_mosi_oe_n) |-> sck_rises == 4'h8)
      else $error("byte ended without eight sck cycles");
   a_sck_idle_low: assert property (
      dev_mosi_oe_n && !dev_sck_oe_n |-> !dev_sck_o)
      else $error("sck not low between bytes");
   a_sck_half_min: assert property (
      !dev_sck_oe_n && $changed(dev_sck_o) |=> $stable(dev_sck_o))
      else $error("sck half period under two clocks");
   a_mosi_in_master: assert property (
      !dev_mosi_oe_n |-> !dev_sck_oe_n)
      else $error("mosi driven without master sck");
   a_miso_in_slave: assert property (
      !dev_miso_oe_n |-> dev_sck_oe_n && dev_mosi_oe_n)
      else $error("miso driven while sck or mosi driven");
   a_miso_needs_sel: assert property (
      ss_n [*4] |-> dev_miso_oe_n)
      else $error("miso driven while not selected");
   a_miso_single: assert property (
      !(!dev_miso_oe_n && !far_miso_oe_n))
      else $error("two drivers on miso");
   a_fault_release: assert property (
      !ss_n |-> ##[0:3] dev_sck_oe_n)
      else $error("sck still driven after select low");
endmodule : spipc_assertions

/* File: spi_pin_and_select_control_tb_top.sv */
// self-checking bench joining the device end and the far end
`timescale 1ns/1ps
module spi_pin_and_select_control_tb_top;
   import spipc_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic master_set = 1'b0, sel_dis = 1'b0, bit_order = 1'b0;
   logic remap = 1'b0, isp = 1'b0, irq_en = 1'b0, fclr = 1'b0;
   logic d_start = 1'b0, f_start = 1'b0, f_master = 1'b0;
   logic [2:0] rate = 3'h0;
   spipc_port_mode_e pmode = SPIPC_PM_PUSHPULL;
   spipc_byte_t d_tx = 8'h00, f_tx = 8'h00, d_rx, f_rx, sh, tx_v, rv;
   logic m_sel, flag, irq, d_busy, d_done, f_done, f_busy, use_remap;
   logic ss_free, seen_sck, seen_miso;
   logic [2:0] sck_pin, miso_pin, mosi_pin, ss_pin;
   int miscompares = 0, checked = 0, cyc = 0;
   spipc_bus_if bus ();
   spipc_device spipc_device_i (.i_clock(i_clock), .i_rst(i_rst),
      .bus(bus), .i_port_enable(1'b1), .i_master_set(master_set),
      .i_select_disable(sel_dis), .i_select_ignore(1'b0),
      .i_clock_phase(1'b0), .i_bit_order_select(bit_order),
      .i_remap(remap), .i_isp_active(isp), .i_rate_select_bits(rate),
      .i_timer1_overflow(1'b0), .i_interrupt_enable(irq_en),
      .i_fault_clear(fclr), .i_port_mode(pmode), .i_start(d_start),
      .i_tx_byte(d_tx), .o_master_select(m_sel),
      .o_mode_fault_flag(flag), .o_irq(irq), .o_busy(d_busy),
      .o_done(d_done), .o_rx_byte(d_rx), .o_use_remap(use_remap),
      .o_sck_pin(sck_pin), .o_miso_pin(miso_pin), .o_mosi_pin(mosi_pin),
      .o_ss_pin(ss_pin), .o_ss_gpio_free(ss_free));
   spipc_far spipc_far_i (.i_clock(i_clock), .i_rst(i_rst), .bus(bus),
      .i_act_master(f_master), .i_lsb_first(bit_order),
      .i_start(f_start), .i_tx_byte(f_tx), .o_rx_byte(f_rx),
      .o_done(f_done), .o_busy(f_busy));
   spipc_assertions spipc_assertions_i (.i_clock(i_clock), .i_rst(i_rst),
      .dev_sck_o(bus.dev_sck_o), .dev_sck_oe_n(bus.dev_sck_oe_n),
      .dev_mosi_oe_n(bus.dev_mosi_oe_n), .dev_miso_oe_n(bus.dev_miso_oe_n),
      .far_miso_oe_n(bus.far_miso_oe_n), .ss_n(bus.ss_n));
   always #5 i_clock = ~i_clock;
   // mosi as seen on the wire at each rising sck
   always @(posedge bus.sck) sh <= {sh[6:0], bus.mosi};
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic xfer(input bit dgo, input spipc_byte_t dt, ft);
      bit dd, fd;
      dd = !dgo;
      fd = 1'b0;
      sh = 8'h00;
      seen_sck = 1'b0;
      seen_miso = 1'b0;
      d_tx = dt;
      f_tx = ft;
      d_start = dgo;
      f_start = 1'b1;
      @(negedge i_clock);
      d_start = 1'b0;
      f_start = 1'b0;
      for (int n = 0; n < 3000 && !(dd && fd); n++) begin
         @(posedge i_clock);
         #1;
         dd |= d_done;
         fd |= f_done;
         seen_sck |= !bus.dev_sck_oe_n;
         seen_miso |= !bus.dev_miso_oe_n;
      end
      @(negedge i_clock);
   endtask : xfer
   task wrap_up;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (8) @(negedge i_clock);
      i_rst = 1'b0;
      repeat (2) @(negedge i_clock);
      `CHK(m_sel, 1'b0)
      `CHK(bus.dev_sck_oe_n, 1'b1)
      for (int k = 0; k < 4; k++) begin
         {isp, remap} = k[1:0];
         #1;
         `CHK({sck_pin, miso_pin, mosi_pin, ss_pin}, k ? 12'hfac : 12'hd79)
         `CHK(use_remap, k != 0)
      end
      {isp, remap} = 2'b00;
      $display("test pin placement done");
      master_set = 1'b1;
      @(negedge i_clock);
      master_set = 1'b0;
      repeat (3) @(negedge i_clock);
      `CHK(m_sel, 1'b1)
      for (int k = 0; k < 4; k++) begin
         bit_order = k[0];
         pmode = spipc_port_mode_e'({1'b0, k[1]});
         rate = k[2:0];
         tx_v = 8'ha5 ^ k[7:0];
         rv = {<<{tx_v}};
         xfer(1'b1, tx_v, 8'h3c + k[7:0]);
         `CHK(d_rx, 8'h3c + k[7:0])
         `CHK(f_rx, tx_v)
         `CHK(sh, bit_order ? rv : tx_v)
         `CHK({seen_sck, seen_miso}, 2'b10)
         `CHK({bus.dev_mosi_oe_n, bus.mosi}, 2'b11)
         `CHK({d_busy, f_busy}, 2'b00)
      end
      pmode = SPIPC_PM_INPUT;
      @(negedge i_clock);
      `CHK(bus.dev_sck_oe_n, 1'b1)
      pmode = SPIPC_PM_PUSHPULL;
      $display("test master transfers done");
      f_master = 1'b1;
      bit_order = 1'b0;
      irq_en = 1'b1;
      xfer(1'b0, 8'h00, 8'h81);
      `CHK({m_sel, bus.dev_sck_oe_n}, 2'b01)
      `CHK({flag, irq}, 2'b11)
      sel_dis = 1'b1;
      @(negedge i_clock);
      sel_dis = 1'b0;
      repeat (20) @(negedge i_clock);
      `CHK(flag, 1'b1)
      `CHK(m_sel, 1'b0)
      fclr = 1'b1;
      @(negedge i_clock);
      fclr = 1'b0;
      @(negedge i_clock);
      `CHK({flag, irq}, 2'b00)
      $display("test mode fault done");
      xfer(1'b1, 8'h5a, 8'hc3);
      `CHK(d_rx, 8'hc3)
      `CHK(f_rx, 8'h5a)
      `CHK({seen_sck, seen_miso}, 2'b01)
      repeat (4) @(negedge i_clock);
      `CHK(bus.dev_miso_oe_n, 1'b1)
      f_master = 1'b0;
      master_set = 1'b1;
      @(negedge i_clock);
      master_set = 1'b0;
      repeat (3) @(negedge i_clock);
      `CHK(m_sel, 1'b1)
      $display("test slave transfer done");
      wrap_up();
   end
endmodule : spi_pin_and_select_control_tb_top
